// ===== design/csf_pkg.sv
// Constants, operation codes and register map of the core sequencer and flags block.
package csf_pkg;

    // -----------------------------------------------------------------
    // Widths and fixed addresses
    // -----------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int FP_W = 10;
    localparam logic [9:0] FP_RESET = 10'h000;
    localparam logic [9:0] TEST_AREA_LO = 10'h3EA;
    localparam logic [3:0] WORD_ZERO = 4'h0;
    localparam logic [3:0] LAST_WORD = 4'hF;
    localparam logic [3:0] ACC_ONES = 4'hF;
    localparam int MSB = 3;

    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [5:0] REG_CTRL0 = 6'h00;
    localparam logic [5:0] REG_FP_LO = 6'h01;
    localparam logic [5:0] REG_FP_HI = 6'h02;
    localparam logic [5:0] REG_FLAGS = 6'h03;
    localparam logic [5:0] REG_ACC = 6'h04;
    localparam logic [5:0] REG_TBL_LO = 6'h05;
    localparam logic [5:0] REG_TBL_HI = 6'h06;
    localparam logic [1:0] SEL_WORD = 2'h1;
    localparam logic [1:0] SEL_NIB_A = 2'h2;
    localparam logic [1:0] SEL_NIB_B = 2'h3;
    localparam logic [7:0] CTRL0_RESET = 8'h03;
    localparam int CTRL0_DP_LO = 4;
    localparam int CTRL0_DP_HI = 5;
    localparam int FLG_CARRY = 0;
    localparam int FLG_STATUS = 1;
    localparam int FLG_DEPTH = 2;
    localparam int FLG_STANDBY = 3;
    localparam int FLG_SAVE_OK = 4;

    // -----------------------------------------------------------------
    // Status test operand codes
    // -----------------------------------------------------------------
    localparam logic [2:0] TST_KEY_A = 3'h0;
    localparam logic [2:0] TST_KEY_B = 3'h3;
    localparam logic [2:0] TST_KEY_C = 3'h6;
    localparam logic [2:0] TST_TIMER = 3'h5;
    localparam int TST_SENSE_BIT = 3;

    // -----------------------------------------------------------------
    // Operations presented by the instruction decoder
    // -----------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NEXT = 5'h00, OP_JUMP = 5'h01, OP_JUMP_C = 5'h02, OP_JUMP_NC = 5'h03,
        OP_JUMP_F = 5'h04, OP_JUMP_NF = 5'h05, OP_CALL = 5'h06, OP_EXIT = 5'h07,
        OP_AND = 5'h08, OP_XOR = 5'h09, OP_OR = 5'h0A, OP_ROT = 5'h0B,
        OP_ROTZ = 5'h0C, OP_INC = 5'h0D, OP_SCAN = 5'h0E, OP_MOVE = 5'h0F,
        OP_IN = 5'h10, OP_TEST = 5'h11, OP_HALT = 5'h12, OP_TABLE = 5'h13
    } csf_op_type;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_STANDBY = 2'b10
    } csf_state_type;

endpackage

// ===== design/csf_core.sv
// Program sequencer, return stack, data memory, table pointer, accumulator and flags.
//
// The placing of the registers and strobed register access were decided locally.
module csf_core #(
    parameter int ROM_STEPS = 512
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic exec_valid,
    input wire csf_pkg::csf_op_type exec_op,
    input wire logic [9:0] exec_operand,
    input wire logic [1:0] exec_len,
    input wire logic [3:0] port_data,
    input wire logic [3:0] key_return_pins,
    input wire logic sense_pin_zero,
    input wire logic sense_led_pin,
    input wire logic timer_zero,
    input wire logic [5:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    output logic [9:0] fetch_pointer,
    output logic [9:0] rom_table_pointer,
    output logic [3:0] acc,
    output logic carry_bit,
    output logic status_flag,
    output logic stack_depth_bit,
    output logic standby,
    output logic sys_reset_out
);

    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    logic [5:0] pin_s1, pin_s2, pin_s3, pin_val;
    logic [7:0] mem [1:15];
    logic [7:0] word_zero;
    logic [7:0] control_reg_zero;
    logic [1:0] save_hi;
    logic save_ok;
    logic sys_reset_req;
    csf_pkg::csf_state_type state;
    logic go;
    logic [9:0] next_fp;
    logic next_reset;
    logic test_true;
    logic wake;
    logic [1:0] sel;
    logic [3:0] widx;
    logic touch_last;

    // True when a program address holds usable code or table data.
    function automatic logic usable(input logic [9:0] a);
        usable = (32'(a) < ROM_STEPS) && (a < csf_pkg::TEST_AREA_LO);
    endfunction

    // Returns one data word, word zero held apart for its reset.
    function automatic logic [7:0] word_at(input logic [3:0] i);
        word_at = (i == csf_pkg::WORD_ZERO) ? word_zero : mem[i];
    endfunction

    // Returns the save register formed from its upper bits and the last word.
    function automatic logic [9:0] save_addr();
        save_addr = {save_hi, mem[csf_pkg::LAST_WORD]};
    endfunction

    // -----------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------
    // Three stages; a new level is accepted once stages two and three agree.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1 <= 6'h00;
            pin_s2 <= 6'h00;
            pin_s3 <= 6'h00;
            pin_val <= 6'h00;
        end else begin
            pin_s1 <= {sense_led_pin, sense_pin_zero, key_return_pins};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            if (pin_s2 == pin_s3) begin
                pin_val <= pin_s3;
            end
        end
    end

    // -----------------------------------------------------------------
    // Decode
    // -----------------------------------------------------------------
    // Status test condition and the standby wake condition.
    always_comb begin
        case (exec_operand[2:0])
            csf_pkg::TST_KEY_A, csf_pkg::TST_KEY_B, csf_pkg::TST_KEY_C: begin
                test_true = |pin_val[3:0];
            end
            csf_pkg::TST_TIMER: begin
                test_true = timer_zero;
            end
            default: begin
                test_true = 1'b0;
            end
        endcase
        if (exec_operand[csf_pkg::TST_SENSE_BIT] && (|pin_val[5:4])) begin
            test_true = 1'b1;
        end
        wake = |pin_val[3:0];
    end

    assign go = exec_valid && (state == csf_pkg::ST_RUN) && !sys_reset_req;
    assign sel = addr[5:4];
    assign widx = (sel == csf_pkg::SEL_WORD) ? addr[3:0] : addr[4:1];
    assign touch_last = (wr_en || rd_en) && (sel != 2'h0) && (widx == csf_pkg::LAST_WORD);

    // Next fetch pointer and the depth fault request.
    always_comb begin
        next_fp = fetch_pointer + 10'(exec_len);
        next_reset = 1'b0;
        case (exec_op)
            csf_pkg::OP_JUMP: next_fp = exec_operand;
            csf_pkg::OP_JUMP_C: if (carry_bit) next_fp = exec_operand;
            csf_pkg::OP_JUMP_NC: if (!carry_bit) next_fp = exec_operand;
            csf_pkg::OP_JUMP_F: if (status_flag) next_fp = exec_operand;
            csf_pkg::OP_JUMP_NF: if (!status_flag) next_fp = exec_operand;
            csf_pkg::OP_CALL: begin
                next_fp = exec_operand;
                next_reset = stack_depth_bit;
            end
            csf_pkg::OP_EXIT: begin
                next_fp = save_addr();
                next_reset = !stack_depth_bit;
            end
            csf_pkg::OP_TABLE: if (!usable(rom_table_pointer)) next_fp = csf_pkg::FP_RESET;
            default: begin
            end
        endcase
        if (!usable(next_fp)) begin
            next_fp = csf_pkg::FP_RESET;
        end
    end

    // -----------------------------------------------------------------
    // Sequencer
    // -----------------------------------------------------------------
    // Fetch pointer; zero on reset and on a depth fault.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fetch_pointer <= csf_pkg::FP_RESET;
        end else if (sys_reset_req) begin
            fetch_pointer <= csf_pkg::FP_RESET;
        end else if (go && exec_op != csf_pkg::OP_HALT) begin
            fetch_pointer <= next_fp;
        end
    end

    // Depth bit; call and return move it, and the internal system reset clears it.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stack_depth_bit <= 1'b0;
        end else if (sys_reset_req) begin
            stack_depth_bit <= 1'b0;
        end else if (go && exec_op == csf_pkg::OP_CALL) begin
            stack_depth_bit <= 1'b1;
        end else if (go && exec_op == csf_pkg::OP_EXIT) begin
            stack_depth_bit <= 1'b0;
        end
    end

    // Internal system reset raised by a depth overflow or underflow.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sys_reset_req <= 1'b0;
            sys_reset_out <= 1'b0;
        end else begin
            sys_reset_req <= go && next_reset;
            sys_reset_out <= go && next_reset;
        end
    end

    // Run and standby state; a halt skips standby when wake or the status flag already holds.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= csf_pkg::ST_RUN;
            standby <= 1'b0;
        end else begin
            case (state)
                csf_pkg::ST_RUN: begin
                    if (go && exec_op == csf_pkg::OP_HALT && !wake && !status_flag) begin
                        state <= csf_pkg::ST_STANDBY;
                        standby <= 1'b1;
                    end
                end
                csf_pkg::ST_STANDBY: begin
                    if (wake || sys_reset_req) begin
                        state <= csf_pkg::ST_RUN;
                        standby <= 1'b0;
                    end
                end
                default: begin
                    state <= csf_pkg::ST_RUN;
                    standby <= 1'b0;
                end
            endcase
        end
    end

    // Status flag from tests, halts and the end of standby.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_flag <= 1'b0;
        end else if (state == csf_pkg::ST_STANDBY && wake) begin
            status_flag <= 1'b1;
        end else if (go && exec_op == csf_pkg::OP_TEST) begin
            status_flag <= test_true;
        end else if (go && exec_op == csf_pkg::OP_HALT) begin
            status_flag <= wake;
        end
    end

    // -----------------------------------------------------------------
    // Accumulator and carry
    // -----------------------------------------------------------------
    // Accumulator has no reset, so its value is unknown until loaded.
    always_ff @(posedge clk) begin
        if (go) begin
            case (exec_op)
                csf_pkg::OP_AND: acc <= acc & exec_operand[3:0];
                csf_pkg::OP_XOR: acc <= acc ^ exec_operand[3:0];
                csf_pkg::OP_OR: acc <= acc | exec_operand[3:0];
                csf_pkg::OP_ROT: acc <= {acc[2:0], acc[csf_pkg::MSB]};
                csf_pkg::OP_ROTZ: acc <= {acc[2:0], 1'b0};
                csf_pkg::OP_INC: acc <= acc + 4'h1;
                csf_pkg::OP_MOVE: acc <= exec_operand[3:0];
                csf_pkg::OP_IN: acc <= port_data;
                default: acc <= acc;
            endcase
        end
    end

    // Carry flag updates.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            carry_bit <= 1'b0;
        end else if (go) begin
            case (exec_op)
                csf_pkg::OP_AND, csf_pkg::OP_XOR: begin
                    carry_bit <= acc[csf_pkg::MSB] & exec_operand[csf_pkg::MSB];
                end
                csf_pkg::OP_ROT, csf_pkg::OP_ROTZ: begin
                    carry_bit <= acc[csf_pkg::MSB];
                end
                csf_pkg::OP_INC, csf_pkg::OP_SCAN: begin
                    carry_bit <= (acc == csf_pkg::ACC_ONES);
                end
                csf_pkg::OP_OR, csf_pkg::OP_MOVE, csf_pkg::OP_IN: begin
                    carry_bit <= 1'b0;
                end
                default: begin
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Data memory and return address save register
    // -----------------------------------------------------------------
    // Word zero clears on any reset and doubles as the table low byte.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            word_zero <= 8'h00;
        end else if (sys_reset_req) begin
            word_zero <= 8'h00;
        end else if (wr_en && sel == csf_pkg::SEL_WORD && widx == csf_pkg::WORD_ZERO) begin
            word_zero <= wr_data;
        end else if (wr_en && sel[1] && widx == csf_pkg::WORD_ZERO) begin
            if (addr[0]) begin
                word_zero[7:4] <= wr_data[3:0];
            end else begin
                word_zero[3:0] <= wr_data[3:0];
            end
        end
    end

    // Other words keep their contents over reset; a call stores the low return byte.
    always_ff @(posedge clk) begin
        for (int k = 1; k < 16; k++) begin
            if (go && exec_op == csf_pkg::OP_CALL && 4'(k) == csf_pkg::LAST_WORD) begin
                mem[k] <= fetch_pointer[7:0];
            end else if (wr_en && sel == csf_pkg::SEL_WORD && widx == 4'(k)) begin
                mem[k] <= wr_data;
            end else if (wr_en && sel[1] && widx == 4'(k)) begin
                if (addr[0]) begin
                    mem[k][7:4] <= wr_data[3:0];
                end else begin
                    mem[k][3:0] <= wr_data[3:0];
                end
            end
        end
    end

    // Upper save bits; kept over reset, spoilt when the last word is used as data.
    always_ff @(posedge clk) begin
        if (go && exec_op == csf_pkg::OP_CALL) begin
            save_hi <= fetch_pointer[9:8];
            save_ok <= 1'b1;
        end else if (touch_last) begin
            save_hi <= 2'h0;
            save_ok <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Control register zero and table pointer
    // -----------------------------------------------------------------
    // Control register zero; only its pointer bits are used here.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            control_reg_zero <= csf_pkg::CTRL0_RESET;
        end else if (sys_reset_req) begin
            control_reg_zero <= csf_pkg::CTRL0_RESET;
        end else if (wr_en && addr == csf_pkg::REG_CTRL0) begin
            control_reg_zero <= wr_data;
        end
    end

    // Table pointer, refreshed every cycle from its two sources.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rom_table_pointer <= csf_pkg::FP_RESET;
        end else begin
            rom_table_pointer <= {control_reg_zero[csf_pkg::CTRL0_DP_HI],
                                  control_reg_zero[csf_pkg::CTRL0_DP_LO], word_zero};
        end
    end

    // -----------------------------------------------------------------
    // Register read port
    // -----------------------------------------------------------------
    // Read data stand one cycle after the read strobe, zero otherwise.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= 8'h00;
        end else if (!rd_en) begin
            rd_data <= 8'h00;
        end else if (sel == csf_pkg::SEL_WORD) begin
            rd_data <= word_at(widx);
        end else if (sel[1]) begin
            rd_data <= addr[0] ? {4'h0, 4'(word_at(widx) >> 4)} : {4'h0, 4'(word_at(widx))};
        end else begin
            case (addr)
                csf_pkg::REG_CTRL0: rd_data <= control_reg_zero;
                csf_pkg::REG_FP_LO: rd_data <= fetch_pointer[7:0];
                csf_pkg::REG_FP_HI: rd_data <= {6'h00, fetch_pointer[9:8]};
                csf_pkg::REG_FLAGS: rd_data <= {3'h0, save_ok, standby, stack_depth_bit,
                                                status_flag, carry_bit};
                csf_pkg::REG_ACC: rd_data <= {4'h0, acc};
                csf_pkg::REG_TBL_LO: rd_data <= rom_table_pointer[7:0];
                csf_pkg::REG_TBL_HI: rd_data <= {6'h00, rom_table_pointer[9:8]};
                default: rd_data <= 8'h00;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_advance;
        go && exec_op == csf_pkg::OP_NEXT && usable(fetch_pointer + 10'(exec_len))
        |=> fetch_pointer == $past(fetch_pointer) + 10'($past(exec_len));
    endproperty
    a_advance: assert property (p_advance) else $error("pointer did not advance");

    property p_jump;
        go && exec_op == csf_pkg::OP_JUMP && usable(exec_operand)
        |=> fetch_pointer == $past(exec_operand);
    endproperty
    a_jump: assert property (p_jump) else $error("jump target not loaded");

    property p_call_save;
        go && exec_op == csf_pkg::OP_CALL && !stack_depth_bit
        |=> save_addr() == $past(fetch_pointer) && stack_depth_bit;
    endproperty
    a_call_save: assert property (p_call_save) else $error("call did not save");

    property p_overflow;
        go && exec_op == csf_pkg::OP_CALL && stack_depth_bit
        |=> sys_reset_req ##1 fetch_pointer == csf_pkg::FP_RESET && !stack_depth_bit;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not reset");

    property p_underflow;
        go && exec_op == csf_pkg::OP_EXIT && !stack_depth_bit
        |=> ##1 fetch_pointer == csf_pkg::FP_RESET;
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow not reset");

    property p_test_area;
        go && exec_op == csf_pkg::OP_JUMP && exec_operand >= csf_pkg::TEST_AREA_LO
        |=> fetch_pointer == csf_pkg::FP_RESET;
    endproperty
    a_test_area: assert property (p_test_area) else $error("test area reached");

    property p_and_carry;
        go && exec_op == csf_pkg::OP_AND
        |=> carry_bit == ($past(acc[3]) && $past(exec_operand[3]));
    endproperty
    a_and_carry: assert property (p_and_carry) else $error("logic carry wrong");

    property p_rot_carry;
        go && exec_op == csf_pkg::OP_ROT |=> carry_bit == $past(acc[3]) && acc[0] == carry_bit;
    endproperty
    a_rot_carry: assert property (p_rot_carry) else $error("rotate carry wrong");

    property p_inc_carry;
        go && exec_op == csf_pkg::OP_INC |=> carry_bit == ($past(acc) == csf_pkg::ACC_ONES);
    endproperty
    a_inc_carry: assert property (p_inc_carry) else $error("increment carry wrong");

    property p_clear_carry;
        go && (exec_op == csf_pkg::OP_OR || exec_op == csf_pkg::OP_MOVE) |=> !carry_bit;
    endproperty
    a_clear_carry: assert property (p_clear_carry) else $error("carry not cleared");

    property p_table;
        ##1 rom_table_pointer == {$past(control_reg_zero[csf_pkg::CTRL0_DP_HI]),
            $past(control_reg_zero[csf_pkg::CTRL0_DP_LO]), $past(word_zero)};
    endproperty
    a_table: assert property (p_table) else $error("table pointer stale");

    property p_halt_clear;
        go && exec_op == csf_pkg::OP_HALT && status_flag && !wake |=> !status_flag && !standby;
    endproperty
    a_halt_clear: assert property (p_halt_clear) else $error("halt flag wrong");

    c_call_return: cover property (go && exec_op == csf_pkg::OP_CALL ##[1:20]
                                   go && exec_op == csf_pkg::OP_EXIT);
    c_standby_wake: cover property (standby ##[1:50] !standby && status_flag);
    c_overflow: cover property (sys_reset_out);
    c_test_true: cover property (go && exec_op == csf_pkg::OP_TEST && test_true);

endmodule

// ===== verification/tb.sv
// Self-checking bench for the core sequencer and flags block.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // -----------------------------------------------------------------
    // Signals
    // -----------------------------------------------------------------
    logic clk = 1'b0, rstn = 1'b0, exec_valid = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic timer_zero = 1'b0, carry_bit, status_flag, stack_depth_bit, standby, sys_reset_out;
    csf_pkg::csf_op_type exec_op = csf_pkg::OP_NEXT, op;
    logic [9:0] exec_operand = 10'h000, fp_e, fetch_pointer, rom_table_pointer, t;
    logic [1:0] exec_len = 2'h1, ln, sense = 2'h0;
    logic [3:0] port_data = 4'h0, acc, a, o, ae, keys = 4'h0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wr_data = 8'h00, rd_data, d, e;
    int fail_count = 0, total_checks = 0, cycles = 0, i;
    csf_pkg::csf_op_type ops [8] = '{csf_pkg::OP_AND, csf_pkg::OP_XOR, csf_pkg::OP_OR,
        csf_pkg::OP_ROT, csf_pkg::OP_ROTZ, csf_pkg::OP_INC, csf_pkg::OP_SCAN, csf_pkg::OP_IN};

    // The clock toggles every 12.5 ns, a period of 25 ns.
    always #12.5 clk = ~clk;

    // The device under test, with key and sense pins driven by the bench.
    csf_core #(.ROM_STEPS(512)) uut (.clk(clk), .rstn(rstn), .exec_valid(exec_valid),
        .exec_op(exec_op), .exec_operand(exec_operand), .exec_len(exec_len),
        .port_data(port_data), .key_return_pins(keys), .sense_pin_zero(sense[0]),
        .sense_led_pin(sense[1]), .timer_zero(timer_zero), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .fetch_pointer(fetch_pointer),
        .rom_table_pointer(rom_table_pointer), .acc(acc), .carry_bit(carry_bit),
        .status_flag(status_flag), .stack_depth_bit(stack_depth_bit), .standby(standby),
        .sys_reset_out(sys_reset_out));

    // Compares and counts one value.
    task check(input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Executes one operation and waits until its results have landed.
    task ex(input csf_pkg::csf_op_type p, input logic [9:0] v, input logic [1:0] n);
        @(posedge clk);
        exec_valid <= 1'b1; exec_op <= p; exec_operand <= v; exec_len <= n;
        @(posedge clk);
        exec_valid <= 1'b0;
        #1;
    endtask
    // Register bus write and read cycles.
    task wr(input logic [5:0] ad, input logic [7:0] v);
        @(posedge clk);
        wr_en <= 1'b1; addr <= ad; wr_data <= v;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task rd(input logic [5:0] ad, output logic [7:0] v);
        @(posedge clk);
        rd_en <= 1'b1; addr <= ad;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask
    // Works out the carry expected after a logic, rotate or count operation.
    function automatic logic cy(csf_pkg::csf_op_type p, logic [3:0] x, logic [3:0] y);
        case (p)
            csf_pkg::OP_AND, csf_pkg::OP_XOR: cy = x[3] & y[3];
            csf_pkg::OP_ROT, csf_pkg::OP_ROTZ: cy = x[3];
            csf_pkg::OP_INC, csf_pkg::OP_SCAN: cy = (x == 4'hF);
            default: cy = 1'b0;
        endcase
    endfunction
    // Works out the accumulator expected after one operation.
    function automatic logic [3:0] av(csf_pkg::csf_op_type p, logic [3:0] x, y, q);
        case (p)
            csf_pkg::OP_AND: av = x & y;
            csf_pkg::OP_XOR: av = x ^ y;
            csf_pkg::OP_OR: av = x | y;
            csf_pkg::OP_ROT: av = {x[2:0], x[3]};
            csf_pkg::OP_ROTZ: av = {x[2:0], 1'b0};
            csf_pkg::OP_INC: av = x + 4'h1;
            csf_pkg::OP_IN: av = q;
            default: av = x;
        endcase
    endfunction
    // Prints the counts and the verdict, then stops.
    task end_sim;
        $display("checks %0d, failures %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            end_sim;
        end
    end

    // Main sequence.
    initial begin
        void'($urandom(96));
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        #1 check(fetch_pointer, 10'h000);
        check(stack_depth_bit, 10'h000);
        check(rom_table_pointer, 10'h000);
        rd(csf_pkg::REG_CTRL0, d);
        check(d, csf_pkg::CTRL0_RESET);
        rd(6'h10, d);
        check(d, 10'h000);
        rd(csf_pkg::REG_FP_HI, d);
        check(d, 10'h000);
        fp_e = 10'h000;
        for (i = 0; i < 20; i++) begin
            t = 10'($urandom % 10'h1C0);
            ln = 2'h1 + 2'($urandom % 2);
            if (i % 4 == 3) begin
                ex(csf_pkg::OP_JUMP, t, ln);
                fp_e = t;
            end else begin
                ex(csf_pkg::OP_NEXT, t, ln);
                fp_e = fp_e + 10'(ln);
            end
            check(fetch_pointer, fp_e);
        end
        ex(csf_pkg::OP_CALL, 10'h050, 2'h1);
        check(fetch_pointer, 10'h050);
        check(stack_depth_bit, 10'h001);
        ex(csf_pkg::OP_EXIT, 10'h000, 2'h1);
        check(fetch_pointer, fp_e);
        check(stack_depth_bit, 10'h000);
        rd(6'h1F, d);
        check(d, fp_e[7:0]);
        ex(csf_pkg::OP_EXIT, 10'h000, 2'h1);
        check(sys_reset_out, 10'h001);
        @(posedge clk);
        #1 check(fetch_pointer, 10'h000);
        ex(csf_pkg::OP_CALL, 10'h0A0, 2'h1);
        ex(csf_pkg::OP_CALL, 10'h0C0, 2'h1);
        check(sys_reset_out, 10'h001);
        @(posedge clk);
        #1 check(stack_depth_bit, 10'h000);
        for (i = 0; i < 48; i++) begin
            a = (i < 8) ? 4'hF : 4'($urandom);
            o = 4'($urandom);
            op = ops[i % 8];
            port_data <= 4'($urandom);
            ex(csf_pkg::OP_MOVE, {6'h00, a}, 2'h1);
            check(carry_bit, 10'h000);
            ex(op, {6'h00, o}, 2'h1);
            check(carry_bit, cy(op, a, o));
            check(acc, av(op, a, o, port_data));
        end
        ae = av(op, a, o, port_data);
        ex(csf_pkg::OP_JUMP, 10'h0F0, 2'h1);
        ex(csf_pkg::OP_JUMP_C, 10'h100, 2'h1);
        check(fetch_pointer, 10'h0F1);
        ex(csf_pkg::OP_JUMP_NC, 10'h120, 2'h1);
        check(fetch_pointer, 10'h120);
        ex(csf_pkg::OP_JUMP, 10'h3EA, 2'h1);
        check(fetch_pointer, 10'h000);
        ex(csf_pkg::OP_JUMP, 10'h200, 2'h1);
        check(fetch_pointer, 10'h000);
        // A second reset in mid-run keeps the other words and the accumulator.
        d = 8'($urandom);
        wr(6'h13, d);
        wr(6'h10, ~d);
        @(posedge clk) rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(6'h13, e);
        check(e, d);
        rd(6'h10, e);
        check(e, 10'h000);
        check(acc, ae);
        for (i = 0; i < 16; i++) begin
            timer_zero <= 1'($urandom);
            ex(csf_pkg::OP_TEST, 10'(i % 8), 2'h1);
            check(status_flag, (i % 8 == 5) & timer_zero);
        end
        // Key and sense pins against status tests, halts and standby.
        keys <= 4'h4;
        repeat (5) @(posedge clk);
        ex(csf_pkg::OP_TEST, 10'h003, 2'h1);
        check(status_flag, 10'h001);
        ex(csf_pkg::OP_HALT, 10'h000, 2'h1);
        check(standby, 10'h000);
        check(status_flag, 10'h001);
        keys <= 4'h0;
        sense <= 2'h2;
        repeat (5) @(posedge clk);
        ex(csf_pkg::OP_TEST, 10'h009, 2'h1);
        check(status_flag, 10'h001);
        ex(csf_pkg::OP_HALT, 10'h000, 2'h1);
        check(status_flag, 10'h000);
        check(standby, 10'h000);
        ex(csf_pkg::OP_HALT, 10'h000, 2'h1);
        check(standby, 10'h001);
        keys <= 4'h8;
        repeat (6) @(posedge clk);
        #1 check(standby, 10'h000);
        check(status_flag, 10'h001);
        ex(csf_pkg::OP_JUMP_F, 10'h140, 2'h1);
        check(fetch_pointer, 10'h140);
        ex(csf_pkg::OP_JUMP_NF, 10'h180, 2'h1);
        check(fetch_pointer, 10'h141);
        d = 8'($urandom);
        o = 4'($urandom);
        wr(6'h10, d);
        wr(csf_pkg::REG_CTRL0, {2'h0, o[1:0], 4'h3});
        repeat (2) @(posedge clk);
        #1 check(rom_table_pointer, {o[1:0], d});
        ex(csf_pkg::OP_JUMP, 10'h100, 2'h1);
        ex(csf_pkg::OP_TABLE, 10'h000, 2'h1);
        check(fetch_pointer, ({o[1:0], d} < 10'h200) ? 10'h101 : 10'h000);
        end_sim;
    end
endmodule
